// *** dv/suc_chk.sv ***
// concurrent checks on the system control block ports
module suc_chk #(
   parameter int SEG_ENTRIES = 23
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclkRise,
   input wire logic regWrite,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic alignPin_n,
   input wire logic segStart,
   input wire logic segCopyDone,
   input wire suc_pkg::suc_copy_type segCopy,
   input wire logic segCopyValid,
   input wire logic segBusy,
   input wire logic updateStrobe,
   input wire logic antiRuntDisable,
   input wire logic alignPowerDown,
   input wire logic distRefPowerDown,
   input wire logic alignForce,
   input wire logic alignTrigger
);
   logic mapped;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   assign mapped = regAddr == 12'h230 || regAddr == 12'h232 || (regAddr >= 12'hA00 && regAddr <= 12'hA16);
   // ======================================
   // update and control bits
   property p_pulse; updateStrobe |=> !updateStrobe; endproperty
   a_pulse: assert property (p_pulse) else $error("update pulse too long");
   property p_sclk; updateStrobe |-> $past(sclkRise); endproperty
   a_sclk: assert property (p_sclk) else $error("update without serial edge");
   property p_upd; regWrite && regAddr == 12'h232 && regWrData[0] ##1 sclkRise |=> updateStrobe; endproperty
   a_upd: assert property (p_upd) else $error("update not done");
   property p_ctl; $changed({antiRuntDisable, alignPowerDown, distRefPowerDown}) |-> updateStrobe; endproperty
   a_ctl: assert property (p_ctl) else $error("control bit moved without update");
   property p_pd; alignForce |-> !alignPowerDown; endproperty
   a_pd: assert property (p_pd) else $error("force while powered down");
   property p_trig; alignTrigger |-> $fell(alignForce); endproperty
   a_trig: assert property (p_trig) else $error("stray trigger");
   property p_fall; $fell(alignForce) && !alignPowerDown |-> alignTrigger; endproperty
   a_fall: assert property (p_fall) else $error("missing trigger");
   property p_pin; (!alignPin_n && !alignPowerDown) [*4] |-> alignForce; endproperty
   a_pin: assert property (p_pin) else $error("pin low not forcing");
   // ======================================
   // register reads and table walk
   property p_rd0; !$past(mapped) |-> regRdData == 8'h00; endproperty
   a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
   property p_rsv; $past(regAddr) == 12'h230 |-> regRdData[7:4] == 4'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved system bits set");
   property p_hold; segCopyValid && !segCopyDone |=> segCopyValid && $stable(segCopy); endproperty
   a_hold: assert property (p_hold) else $error("copy request dropped");
   property p_cnt; segCopyValid |-> segBusy && !segCopy.count[7] && segCopy.count != 8'h00; endproperty
   a_cnt: assert property (p_cnt) else $error("bad copy count");
endmodule : suc_chk

// *** dv/suc_host_model.sv ***
// host side: serial clock edges and eeprom engine acknowledges
module suc_host_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic segCopyValid,
   output logic sclkRise,
   output logic segCopyDone
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   // ======================================
   // serial edge every fourth cycle, ack after a varying wait
   always @(negedge clk) begin
      n <= reset ? 0 : n + 1;
      sclkRise <= (n % 4 == 3);
      segCopyDone <= segCopyValid && (n % 3 == 0);
   end
endmodule : suc_host_model

// *** dv/tb_top.sv ***
// self-checking bench for the system control block
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic regWrite = 1'b0;
   logic alignPin_n = 1'b1;
   logic segStart = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic sclkRise, segCopyDone, segCopyValid, segBusy, updateStrobe;
   logic antiRuntDisable, alignPowerDown, distRefPowerDown, alignForce, alignTrigger;
   suc_pkg::suc_copy_type segCopy;
   int fail_count = 0;
   int comparisons = 0;
   always #50 clk = ~clk;
   sync_update_segment_control sync_update_segment_control_inst (.clk(clk), .reset(reset), .sclkRise(sclkRise),
      .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .alignPin_n(alignPin_n), .segStart(segStart), .segCopyDone(segCopyDone), .segCopy(segCopy),
      .segCopyValid(segCopyValid), .segBusy(segBusy), .updateStrobe(updateStrobe),
      .antiRuntDisable(antiRuntDisable), .alignPowerDown(alignPowerDown), .distRefPowerDown(distRefPowerDown),
      .alignForce(alignForce), .alignTrigger(alignTrigger));
   suc_host_model suc_host_model_inst (.clk(clk), .reset(reset), .segCopyValid(segCopyValid),
      .sclkRise(sclkRise), .segCopyDone(segCopyDone));
   // ======================================
   // bus and wait helpers
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic await(ref logic s, input int lim);
      int i;
      for (i = 0; i < lim && s !== 1'b1; i++) @(negedge clk);
      if (s !== 1'b1) begin
         fail_count++;
         $display("wrong value wait expected 1 seen 0");
         close_out();
      end
   endtask : await
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
      regWrite = 1'b0;
   endtask : wr
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk);
      regAddr = a;
      @(negedge clk);
      `CHK("read data", e, regRdData)
   endtask : rd
   task upd;
      wr(12'h232, 8'h01);
      await(updateStrobe, 12);
   endtask : upd
   // ======================================
   // scenarios
   task t_defaults;
      `CHK("outputs", 5'h00, {antiRuntDisable, alignPowerDown, distRefPowerDown, alignForce, segBusy})
      rd(12'h230, 8'h00);
      rd(12'hA00, 8'h04);
      rd(12'hA15, 8'h80);
      rd(12'hA16, 8'hFF);
      rd(12'hA17, 8'h00);
      rd(12'h231, 8'h00);
      rd(12'h232, 8'h00);
   endtask : t_defaults
   task t_bits;
      wr(12'h230, 8'hF0);
      rd(12'h230, 8'h00);
      for (int b = 1; b < 4; b++) begin
         wr(12'h230, 8'h01 << b);
         rd(12'h230, 8'h01 << b);
         `CHK("held", 3'h0, {antiRuntDisable, alignPowerDown, distRefPowerDown})
         upd();
         `CHK("active", 3'(1 << (b - 1)), {antiRuntDisable, alignPowerDown, distRefPowerDown})
         rd(12'h232, 8'h00);
         wr(12'h230, 8'h00);
         upd();
      end
   endtask : t_bits
   task t_align;
      wr(12'h230, 8'h01);
      upd();
      repeat (2) @(negedge clk);
      `CHK("soft force", 1'b1, alignForce)
      wr(12'h230, 8'h00);
      upd();
      await(alignTrigger, 4);
      `CHK("force off", 1'b0, alignForce)
      wr(12'h230, 8'h05);
      upd();
      repeat (2) @(negedge clk);
      `CHK("masked force", 1'b0, alignForce)
      wr(12'h230, 8'h00);
      upd();
      alignPin_n = 1'b0;
      repeat (5) @(negedge clk);
      `CHK("pin force", 1'b1, alignForce)
      alignPin_n = 1'b1;
      await(alignTrigger, 6);
   endtask : t_align
   task t_walk(input int copies, input int loads);
      logic [11:0] exp [7] = '{12'h000, 12'h010, 12'h0F0, 12'h140, 12'h190, 12'h1E0, 12'h230};
      logic [7:0] expCount [7] = '{8'h04, 8'h1E, 8'h10, 8'h04, 8'h09, 8'h02, 8'h03};
      int n, s, i;
      n = 0;
      s = 0;
      @(negedge clk);
      segStart = 1'b1;
      @(negedge clk);
      segStart = 1'b0;
      for (i = 0; i < 400 && segBusy === 1'b1; i++) begin
         // just past the falling edge, both sides of the copy handshake stand settled
         @(negedge clk);
         #1;
         if (segCopyValid && segCopyDone) begin
            `CHK("copy address", exp[n], segCopy.addr)
            `CHK("copy count", expCount[n], segCopy.count)
            n++;
         end
         s += updateStrobe;
      end
      if (segBusy === 1'b1) begin
         fail_count++;
         $display("wrong value walk end expected 0 seen 1");
         close_out();
      end
      repeat (6) begin
         @(negedge clk);
         #1;
         s += updateStrobe;
      end
      `CHK("copies", copies, n)
      `CHK("loads", loads, s)
   endtask : t_walk
   initial begin
      repeat (10) @(negedge clk);
      reset = 1'b0;
      t_defaults();
      t_bits();
      t_align();
      t_walk(7, 1);
      wr(12'hA00, 8'hFF);
      t_walk(0, 0);
      close_out();
   end
endmodule : tb_top
bind sync_update_segment_control suc_chk #(.SEG_ENTRIES(SEG_ENTRIES)) suc_chk_inst (.clk(clk), .reset(reset),
   .sclkRise(sclkRise), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
   .alignPin_n(alignPin_n), .segStart(segStart), .segCopyDone(segCopyDone), .segCopy(segCopy),
   .segCopyValid(segCopyValid), .segBusy(segBusy), .updateStrobe(updateStrobe), .antiRuntDisable(antiRuntDisable),
   .alignPowerDown(alignPowerDown), .distRefPowerDown(distRefPowerDown), .alignForce(alignForce),
   .alignTrigger(alignTrigger));

// *** hw/suc_pkg.sv ***
// types shared by the system control block
package suc_pkg;

   // ==========================================================
   // system control fields
   typedef struct packed {
      logic antiRuntDisable;
      logic alignPowerDown;
      logic distRefPowerDown;
      logic softAlign;
   } suc_sys_type;

   // ==========================================================
   // one copy request towards the eeprom engine
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] count;
   } suc_copy_type;

   // ==========================================================
   // table walker states
   typedef enum logic [4:0] {
      SUC_IDLE = 5'b00001,
      SUC_FETCH = 5'b00010,
      SUC_ADDR_HI = 5'b00100,
      SUC_ADDR_LO = 5'b01000,
      SUC_COPY = 5'b10000
   } suc_walk_type;

endpackage : suc_pkg

// *** hw/suc_regs.svh ***
// register offsets, field positions, reset values and table codes of the system control block
`ifndef SUC_REGS_SVH
`define SUC_REGS_SVH

// ==========================================================
// register offsets
`define SUC_ADDR_SYSTEM 12'h230
`define SUC_ADDR_UPDATE 12'h232
`define SUC_ADDR_SEG_FIRST 12'hA00
`define SUC_ADDR_SEG_LAST 12'hA16

// ==========================================================
// system register fields
`define SUC_BIT_ANTI_RUNT_DIS 3
`define SUC_BIT_ALIGN_PD 2
`define SUC_BIT_DIST_REF_PD 1
`define SUC_BIT_SOFT_ALIGN 0
`define SUC_SYSTEM_RESET 4'h0

// ==========================================================
// update register field
`define SUC_BIT_UPDATE 0

// ==========================================================
// segment table size and codes
`define SUC_SEG_ENTRIES 23
`define SUC_SEG_IDX_W 5
`define SUC_OP_LOAD 8'h80
`define SUC_OP_END 8'hFF
`define SUC_BIT_OPCODE 7
// power-up table, entry 0 in the lowest byte
`define SUC_SEG_RESET 184'hFF80_3002_03E0_0102_9001_0940_0104_F000_1010_001E_0000_04

`endif

// *** hw/suc_seg_table.sv ***
// eeprom buffer segment table storage with host and walker read ports
`include "suc_regs.svh"
module suc_seg_table #(
   parameter int ENTRIES = `SUC_SEG_ENTRIES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic writeEn,
   input wire logic [`SUC_SEG_IDX_W-1:0] writeIdx,
   input wire logic [7:0] writeData,
   input wire logic [`SUC_SEG_IDX_W-1:0] hostIdx,
   output logic [7:0] hostData,
   input wire logic [`SUC_SEG_IDX_W-1:0] walkIdx,
   output logic [7:0] walkData
);

   localparam logic [ENTRIES*8-1:0] DEFAULTS = `SUC_SEG_RESET;

   logic [7:0] mem [ENTRIES];
   logic [7:0] next_mem [ENTRIES];

   // ==========================================================
   // storage; reset restores the full-transfer table
   genvar gi;
   generate
      for (gi = 0; gi < ENTRIES; gi++) begin : gEntry
         always_comb begin
            next_mem[gi] = mem[gi];
            if (writeEn && (writeIdx == `SUC_SEG_IDX_W'(gi))) begin
               next_mem[gi] = writeData; // RULE_08
            end
         end
         always_ff @(posedge clk) begin
            if (reset) begin
               mem[gi] <= DEFAULTS[gi*8 +: 8]; // RULE_10
            end else begin
               mem[gi] <= next_mem[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // read ports; out-of-range index reads as zero on the host port and as end code on the walker port
   always_comb begin
      hostData = 8'h00;
      walkData = `SUC_OP_END;
      if (int'(hostIdx) < ENTRIES) begin
         hostData = mem[hostIdx];
      end
      if (int'(walkIdx) < ENTRIES) begin
         walkData = mem[walkIdx];
      end
   end

endmodule : suc_seg_table

// *** hw/suc_seg_walker.sv ***
// steps through the segment table issuing copy and load operations
`include "suc_regs.svh"
module suc_seg_walker #(
   parameter int ENTRIES = `SUC_SEG_ENTRIES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic copyDone,
   input wire logic [7:0] entryData,
   output logic [`SUC_SEG_IDX_W-1:0] entryIdx,
   output suc_pkg::suc_copy_type copyReq,
   output logic copyValid,
   output logic loadReq,
   output logic busy
);

   suc_pkg::suc_walk_type state, next_state;
   logic [`SUC_SEG_IDX_W-1:0] next_entryIdx;
   suc_pkg::suc_copy_type next_copyReq;
   logic next_copyValid;
   logic next_loadReq;

   // ==========================================================
   // entries run in ascending order until the end code
   always_comb begin
      next_state = state;
      next_entryIdx = entryIdx;
      next_copyReq = copyReq;
      next_copyValid = copyValid;
      next_loadReq = 1'b0;
      case (state)
         suc_pkg::SUC_IDLE: begin
            if (start) begin
               next_entryIdx = '0;
               next_state = suc_pkg::SUC_FETCH;
            end
         end
         suc_pkg::SUC_FETCH: begin
            next_entryIdx = entryIdx + 1'b1; // RULE_11
            if (int'(entryIdx) >= ENTRIES || entryData == `SUC_OP_END) begin
               next_entryIdx = entryIdx;
               next_state = suc_pkg::SUC_IDLE; // RULE_11
            end else if (entryData == `SUC_OP_LOAD) begin
               next_loadReq = 1'b1; // RULE_09
            end else if (!entryData[`SUC_BIT_OPCODE] && entryData != 8'h00) begin
               next_copyReq.count = entryData; // RULE_08
               next_state = suc_pkg::SUC_ADDR_HI;
            end
         end
         suc_pkg::SUC_ADDR_HI: begin
            next_copyReq.addr[11:8] = entryData[3:0];
            next_entryIdx = entryIdx + 1'b1;
            next_state = suc_pkg::SUC_ADDR_LO;
         end
         suc_pkg::SUC_ADDR_LO: begin
            next_copyReq.addr[7:0] = entryData;
            next_entryIdx = entryIdx + 1'b1;
            next_copyValid = 1'b1;
            next_state = suc_pkg::SUC_COPY;
         end
         suc_pkg::SUC_COPY: begin
            if (copyDone) begin
               next_copyValid = 1'b0;
               next_state = suc_pkg::SUC_FETCH; // RULE_11
            end
         end
         default: begin
            next_state = suc_pkg::SUC_IDLE;
            next_copyValid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= suc_pkg::SUC_IDLE;
         entryIdx <= '0;
         copyReq <= '0;
         copyValid <= 1'b0;
         loadReq <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         entryIdx <= next_entryIdx;
         copyReq <= next_copyReq;
         copyValid <= next_copyValid;
         loadReq <= next_loadReq;
         busy <= (next_state != suc_pkg::SUC_IDLE);
      end
   end

endmodule : suc_seg_walker

// *** hw/sync_update_segment_control.sv ***
// system control bits, update-all strobe and eeprom segment table of the clock distributor
//
// What this block does
// RULE_01: system bit 3 set disables anti-runt circuitry
// RULE_02: system bit 2 set powers down alignment
// RULE_03: system bit 1 set powers down distribution reference
// RULE_04: soft alignment bit high forces static outputs
// RULE_05: soft alignment falling edge triggers alignment event
// RULE_06: update write copies buffers on next serial edge
// RULE_07: update bit clears itself after the copy
// RULE_08: segment table holds 23 address/count registers
// RULE_09: table also holds load and end codes
// RULE_10: default table transfers everything then loads
// RULE_11: entries run ascending, stop at end code
`include "suc_regs.svh"
module sync_update_segment_control #(
   parameter int SEG_ENTRIES = `SUC_SEG_ENTRIES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclkRise,
   input wire logic regWrite,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic alignPin_n,
   input wire logic segStart,
   input wire logic segCopyDone,
   output suc_pkg::suc_copy_type segCopy,
   output logic segCopyValid,
   output logic segBusy,
   output logic updateStrobe,
   output logic antiRuntDisable,
   output logic alignPowerDown,
   output logic distRefPowerDown,
   output logic alignForce,
   output logic alignTrigger
);

   // ==========================================================
   // address decode
   logic hitSystem;
   logic hitUpdate;
   logic hitSeg;
   logic [`SUC_SEG_IDX_W-1:0] segIdx;
   logic [11:0] segOffset;

   always_comb begin
      hitSystem = (regAddr == `SUC_ADDR_SYSTEM);
      hitUpdate = (regAddr == `SUC_ADDR_UPDATE);
      hitSeg = (regAddr >= `SUC_ADDR_SEG_FIRST) && (regAddr <= `SUC_ADDR_SEG_LAST);
      segOffset = regAddr - `SUC_ADDR_SEG_FIRST;
      segIdx = segOffset[`SUC_SEG_IDX_W-1:0];
   end

   // ==========================================================
   // segment table and its walker
   logic [7:0] segHostData;
   logic [7:0] segWalkData;
   logic [`SUC_SEG_IDX_W-1:0] walkIdx;
   logic walkLoad;

   suc_seg_table #(
      .ENTRIES(SEG_ENTRIES)
   ) uTable (
      .clk(clk),
      .reset(reset),
      .writeEn(regWrite && hitSeg),
      .writeIdx(segIdx),
      .writeData(regWrData),
      .hostIdx(segIdx),
      .hostData(segHostData),
      .walkIdx(walkIdx),
      .walkData(segWalkData)
   );

   suc_seg_walker #(
      .ENTRIES(SEG_ENTRIES)
   ) uWalker (
      .clk(clk),
      .reset(reset),
      .start(segStart),
      .copyDone(segCopyDone),
      .entryData(segWalkData),
      .entryIdx(walkIdx),
      .copyReq(segCopy),
      .copyValid(segCopyValid),
      .loadReq(walkLoad),
      .busy(segBusy)
   );

   // ==========================================================
   // alignment pin synchroniser
   logic alignMeta_n;
   logic alignSync_n;

   always_ff @(posedge clk) begin
      if (reset) begin
         alignMeta_n <= 1'b1;
         alignSync_n <= 1'b1;
      end else begin
         alignMeta_n <= alignPin_n;
         alignSync_n <= alignMeta_n;
      end
   end

   // ==========================================================
   // system register: buffer side written by the host
   suc_pkg::suc_sys_type sysBuffer, next_sysBuffer;
   suc_pkg::suc_sys_type sysActive, next_sysActive;

   always_comb begin
      next_sysBuffer = sysBuffer;
      if (regWrite && hitSystem) begin
         next_sysBuffer.antiRuntDisable = regWrData[`SUC_BIT_ANTI_RUNT_DIS]; // RULE_01
         next_sysBuffer.alignPowerDown = regWrData[`SUC_BIT_ALIGN_PD]; // RULE_02
         next_sysBuffer.distRefPowerDown = regWrData[`SUC_BIT_DIST_REF_PD]; // RULE_03
         next_sysBuffer.softAlign = regWrData[`SUC_BIT_SOFT_ALIGN]; // RULE_04
      end
   end

   // ==========================================================
   // update strobe: pending until the next serial edge
   // a new request in the clearing cycle keeps the bit set, so no request is lost
   logic updatePending, next_updatePending;
   logic doUpdate;
   logic next_updateStrobe;

   always_comb begin
      doUpdate = updatePending && sclkRise; // RULE_06
      next_updatePending = updatePending;
      if (doUpdate) begin
         next_updatePending = 1'b0; // RULE_07
      end
      if ((regWrite && hitUpdate && regWrData[`SUC_BIT_UPDATE]) || walkLoad) begin
         next_updatePending = 1'b1; // RULE_06
      end
      next_updateStrobe = doUpdate;
      next_sysActive = sysActive;
      if (doUpdate) begin
         next_sysActive = sysBuffer; // RULE_06
      end
   end

   // ==========================================================
   // alignment control from pin and soft bit
   // powering down the alignment function masks both force and trigger
   // taken from the value being loaded, so force never overlaps the power-down output
   logic next_alignForce;
   logic next_alignTrigger;

   always_comb begin
      next_alignForce = (next_sysActive.softAlign || !alignSync_n) && !next_sysActive.alignPowerDown; // RULE_04
      next_alignTrigger = alignForce && !next_alignForce && !next_sysActive.alignPowerDown; // RULE_05
   end

   // ==========================================================
   // registered read data; unmapped addresses read zero
   logic [7:0] next_regRdData;

   always_comb begin
      next_regRdData = 8'h00;
      if (hitSystem) begin
         next_regRdData[3:0] = sysBuffer;
      end else if (hitUpdate) begin
         next_regRdData[`SUC_BIT_UPDATE] = updatePending;
      end else if (hitSeg) begin
         next_regRdData = segHostData;
      end
   end

   // ==========================================================
   // system register: buffer, active copy and control outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         sysBuffer <= `SUC_SYSTEM_RESET;
         sysActive <= `SUC_SYSTEM_RESET;
         antiRuntDisable <= 1'b0;
         alignPowerDown <= 1'b0;
         distRefPowerDown <= 1'b0;
      end else begin
         sysBuffer <= next_sysBuffer;
         sysActive <= next_sysActive;
         antiRuntDisable <= next_sysActive.antiRuntDisable; // RULE_01
         alignPowerDown <= next_sysActive.alignPowerDown; // RULE_02
         distRefPowerDown <= next_sysActive.distRefPowerDown; // RULE_03
      end
   end

   // ==========================================================
   // update strobe registers
   always_ff @(posedge clk) begin
      if (reset) begin
         updatePending <= 1'b0;
         updateStrobe <= 1'b0;
      end else begin
         updatePending <= next_updatePending;
         updateStrobe <= next_updateStrobe;
      end
   end

   // ==========================================================
   // alignment registers
   always_ff @(posedge clk) begin
      if (reset) begin
         alignForce <= 1'b0;
         alignTrigger <= 1'b0;
      end else begin
         alignForce <= next_alignForce;
         alignTrigger <= next_alignTrigger;
      end
   end

   // ==========================================================
   // read data register
   always_ff @(posedge clk) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= next_regRdData;
      end
   end

endmodule : sync_update_segment_control
